// [bench/rcrp_host_model.sv]
// Purpose: Register host on the far side, issuing AHB-Lite single word transfers.
// Assumes: The slave answers through hready; no wait count is presumed.
// Notes: Released address and hwrite show inverted values, never the last ones.
module rcrp_host_model
  import rcrp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Bus transfer
  // ************************************************************
  // Idle bus at time zero.
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // A status read at code 242 or below also acknowledges the sticky current alert bit.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwrite <= ~wr;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask : xfer
endmodule : rcrp_host_model

// [bench/rcrp_monitor.sv]
// Purpose: Port-level checks of the rail current report and protection block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Windows allow for the two-flop input synchronisers and output registers.
module rcrp_monitor
  import rcrp_pkg::*;
#(
  parameter int unsigned CODE_W = 8,
  parameter int unsigned MV_W = 13
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [CODE_W-1:0] current_monitor_output,
  input wire logic overcurrent_threshold_set,
  input wire logic alert_n,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic pwm_oe,
  input wire logic core_rail_shutdown_req,
  input wire logic overcurrent_latch,
  input wire logic overvoltage_latch,
  input wire logic negative_voltage_guard
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Sequences and properties
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // A level counts only once it has had time to pass the synchronisers.
  sequence s_code_full;
    (current_monitor_output == 8'hff) [*4];
  endsequence
  sequence s_code_high;
    (current_monitor_output > 8'hf2) [*4];
  endsequence
  sequence s_limit_held;
    overcurrent_threshold_set [*4];
  endsequence

  property p_alert_set;
    s_code_full |-> ##[0:2] !alert_n;
  endproperty
  property p_alert_hold;
    s_code_high ##0 !alert_n |=> !alert_n;
  endproperty
  property p_alert_clear;
    (current_monitor_output <= 8'hf2) [*6] |-> alert_n;
  endproperty
  property p_limit_off;
    s_limit_held |-> !high_side_gate;
  endproperty
  property p_oc_tristate;
    overcurrent_latch [*2] |-> !pwm_oe && !high_side_gate;
  endproperty
  property p_fault_req;
    (overcurrent_latch || overvoltage_latch) |-> ##[0:1] core_rail_shutdown_req;
  endproperty
  property p_latch_hold;
    (overcurrent_latch |=> overcurrent_latch) and (overvoltage_latch |=> overvoltage_latch);
  endproperty
  property p_ov_clamp;
    (overvoltage_latch && !negative_voltage_guard) [*2] |-> low_side_gate && !high_side_gate;
  endproperty
  property p_nv_arm;
    negative_voltage_guard |-> overvoltage_latch;
  endproperty
  property p_nv_clamp;
    negative_voltage_guard [*2] |-> !low_side_gate && !high_side_gate;
  endproperty

  a_alert_set: assert property (p_alert_set) else $error("alert not driven at full code");
  a_alert_hold: assert property (p_alert_hold) else $error("alert left early");
  a_alert_clear: assert property (p_alert_clear) else $error("alert stuck low");
  a_limit_off: assert property (p_limit_off) else $error("high side on in limit");
  a_oc_tristate: assert property (p_oc_tristate) else $error("pwm driven in latch");
  a_fault_req: assert property (p_fault_req) else $error("core shutdown missing");
  a_latch_hold: assert property (p_latch_hold) else $error("fault latch cleared");
  a_ov_clamp: assert property (p_ov_clamp) else $error("wrong gates in overvoltage");
  a_nv_arm: assert property (p_nv_arm) else $error("guard without latch");
  a_nv_clamp: assert property (p_nv_clamp) else $error("wrong gates in guard");
endmodule : rcrp_monitor

// [bench/tb_rail_current_report_protect.sv]
// Purpose: Self-checking bench for the rail current report and protection block.
// Assumes: Inputs change by non-blocking assignment just after a rising edge.
// Notes: Waits cover the input synchronisers and the 25-cycle glitch filters.
module tb_rail_current_report_protect
  import rcrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, alert_n, hsg, lsg, pwm, pwm_oe, req, ocl, ovl, nvg;
  logic fb = 1'b0, qrw = 1'b0, ocs = 1'b0, cyc_st = 1'b0, on_t = 1'b0;
  logic [31:0] hrdata, hwdata, rdv;
  logic [7:0] haddr;
  logic [7:0] code = 8'h00;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic signed [12:0] sense = 13'sd0;
  logic [11:0] ofs = 12'h000;
  logic [31:0] lfsr = 32'h6ba1;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int code_q[$];

  rcrp_top i_rcrp_top (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .current_monitor_output(code),
    .current_monitor_feedback(fb), .quick_response_width_set(qrw),
    .overcurrent_threshold_set(ocs), .sense_negative_input(sense), .offset_setting_pin(ofs),
    .cycle_start(cyc_st), .normal_on_time(on_t), .alert_n(alert_n), .high_side_gate(hsg),
    .low_side_gate(lsg), .pwm_out(pwm), .pwm_oe(pwm_oe), .core_rail_shutdown_req(req),
    .overcurrent_latch(ocl), .overvoltage_latch(ovl), .negative_voltage_guard(nvg));
  rcrp_host_model i_rcrp_host_model (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // ************************************************************
  // Clock, timeout and helpers
  // ************************************************************
  // A 40 ns clock.
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Ceiling well above the several hundred cycles the tests need.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk_pin(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_pin

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: register read got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  // Next state of the stimulus shift register.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : step

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_rcrp_host_model.xfer(1'b0, a, 32'h0, d);
    chk_reg(d, exp);
  endtask : rd

  // One switching cycle is four clocks, opened by a cycle marker.
  task automatic pulses(input int n);
    repeat (n) begin
      cyc_st <= 1'b1;
      step(2);
      cyc_st <= 1'b0;
      step(2);
    end
  endtask : pulses

  task automatic do_reset();
    srst <= 1'b1;
    step(8);
    srst <= 1'b0;
    step(1);
  endtask : do_reset

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    do_reset();
    chk_pin(alert_n, 1'b1, "alert after reset");
    rd(REG_MAX_VID, 32'h5f0);
    rd(8'h10, 32'h0);
    chk_pin(hresp, 1'b0, "okay response");
    // Random codes below full scale pass through a queue as the expected model.
    repeat (6) begin
      lfsr = lfsr_next(lfsr);
      code <= (lfsr[7:0] == 8'hff) ? 8'h00 : lfsr[7:0];
      code_q.push_back((lfsr[7:0] == 8'hff) ? 0 : int'(lfsr[7:0]));
      step(5);
      rd(REG_OUT_CURRENT, 32'(code_q.pop_front()));
    end
    $display("Test done: current code");
    code <= CUR_CODE_MAX;
    step(6);
    chk_pin(alert_n, 1'b0, "alert at full code");
    rd(REG_STATUS1, 32'h1 << STATUS1_ICC_BIT);
    code <= 8'hfa;
    step(6);
    chk_pin(alert_n, 1'b0, "alert in band");
    rd(REG_STATUS1, 32'h1 << STATUS1_ICC_BIT);
    code <= CUR_CODE_RELEASE;
    step(6);
    chk_pin(alert_n, 1'b1, "alert released");
    rd(REG_STATUS1, 32'h1 << STATUS1_ICC_BIT);
    rd(REG_STATUS1, 32'h0);
    $display("Test done: alert");
    on_t <= 1'b1;
    step(5);
    chk_pin(hsg, 1'b1, "normal on-time");
    chk_pin(pwm, 1'b1, "pwm follows on-time");
    chk_pin(pwm_oe, 1'b1, "pwm enabled");
    ocs <= 1'b1;
    step(5);
    chk_pin(hsg, 1'b0, "limit holds gate off");
    ocs <= 1'b0;
    on_t <= 1'b0;
    fb <= 1'b1;
    qrw <= 1'b1;
    step(5);
    chk_pin(hsg, 1'b1, "quick response pulse");
    fb <= 1'b0;
    qrw <= 1'b0;
    step(5);
    chk_pin(hsg, 1'b0, "pulse ended");
    $display("Test done: gate drive");
    ocs <= 1'b1;
    pulses(13);
    chk_pin(ocl, 1'b0, "short overcurrent run");
    ocs <= 1'b0;
    pulses(2);
    ocs <= 1'b1;
    pulses(13);
    chk_pin(ocl, 1'b0, "count restarted");
    pulses(3);
    chk_pin(ocl, 1'b1, "overcurrent latched");
    step(1);
    chk_pin(pwm_oe, 1'b0, "pwm high impedance");
    chk_pin(pwm, 1'b0, "pwm low in latch");
    chk_pin(hsg, 1'b0, "gate drive off");
    chk_pin(req, 1'b1, "core shutdown on overcurrent");
    ocs <= 1'b0;
    pulses(3);
    chk_pin(ocl, 1'b1, "overcurrent held");
    $display("Test done: overcurrent");
    do_reset();
    sense <= -13'sd100;
    step(30);
    chk_pin(nvg, 1'b0, "guard idle without latch");
    i_rcrp_host_model.xfer(1'b1, REG_MAX_VID, 32'h400, rdv);
    rd(REG_MAX_VID, 32'h400);
    sense <= 13'sd1174;
    step(40);
    chk_pin(ovl, 1'b0, "at threshold");
    sense <= 13'sd1175;
    step(20);
    sense <= 13'sd1000;
    step(10);
    chk_pin(ovl, 1'b0, "glitch filtered");
    sense <= 13'sd1175;
    step(30);
    chk_pin(ovl, 1'b1, "overvoltage latched");
    chk_pin(lsg, 1'b1, "low side on");
    chk_pin(hsg, 1'b0, "high side off");
    chk_pin(req, 1'b1, "core shutdown on overvoltage");
    rd(REG_FAULTS, 32'h2);
    sense <= -13'sd50;
    step(35);
    chk_pin(nvg, 1'b0, "guard at trip level");
    sense <= -13'sd51;
    step(30);
    chk_pin(nvg, 1'b1, "guard set");
    chk_pin(lsg, 1'b0, "low side off in guard");
    sense <= 13'sd0;
    step(5);
    chk_pin(nvg, 1'b1, "guard held at zero");
    sense <= 13'sd1;
    step(5);
    chk_pin(lsg, 1'b1, "low side on again");
    chk_pin(ovl, 1'b1, "overvoltage held");
    $display("Test done: overvoltage");
    ofs <= 12'h385;
    sense <= 13'sd0;
    do_reset();
    sense <= 13'sd2370;
    step(40);
    chk_pin(ovl, 1'b0, "wide margin threshold");
    sense <= 13'sd2371;
    step(30);
    chk_pin(ovl, 1'b1, "wide margin trip");
    rd(REG_FAULTS, 32'ha);
    $display("Test done: offset margin");
    end_sim();
  end
endmodule : tb_rail_current_report_protect

bind rcrp_top rcrp_monitor #(.CODE_W(CODE_W), .MV_W(MV_W)) i_rcrp_monitor (
  .ref_clk(ref_clk), .srst(srst), .current_monitor_output(current_monitor_output),
  .overcurrent_threshold_set(overcurrent_threshold_set), .alert_n(alert_n),
  .high_side_gate(high_side_gate), .low_side_gate(low_side_gate), .pwm_oe(pwm_oe),
  .core_rail_shutdown_req(core_rail_shutdown_req), .overcurrent_latch(overcurrent_latch),
  .overvoltage_latch(overvoltage_latch), .negative_voltage_guard(negative_voltage_guard));

// [rtl/rcrp_pkg.sv]
// Purpose: Shared constants for the graphics-rail current report and protection block.
// Assumes: 25 MHz reference clock, AHB-Lite register access with 32-bit data.
// Notes: Register offsets are byte addresses of aligned words.
package rcrp_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned OV_FILTER_NS = 1000;
  localparam int unsigned NV_FILTER_NS = 1000;
  // A least time rounds up to whole cycles.
  localparam int unsigned OV_FILTER_CYC = (OV_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned NV_FILTER_CYC = (NV_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned OC_LATCH_CYCLES = 15;

  // ************************************************************
  // Current code thresholds
  // ************************************************************
  localparam logic [7:0] CUR_CODE_MAX = 8'hff;
  localparam logic [7:0] CUR_CODE_RELEASE = 8'hf2;

  // ************************************************************
  // Voltage margins in millivolts (sensed code is 1 mV per LSB)
  // ************************************************************
  localparam logic [11:0] OV_MARGIN_MV = 12'h096;
  localparam logic [11:0] OV_MARGIN_OFS_MV = 12'h352;
  localparam logic [11:0] OFS_STRAP_MV = 12'h384;
  localparam logic signed [12:0] NV_TRIP_MV = -13'sd50;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] REG_STATUS1 = 8'h00;
  localparam logic [7:0] REG_OUT_CURRENT = 8'h04;
  localparam logic [7:0] REG_MAX_VID = 8'h08;
  localparam logic [7:0] REG_FAULTS = 8'h0c;
  localparam int unsigned STATUS1_ICC_BIT = 2;
  localparam logic [11:0] MAX_VID_RESET = 12'h5f0;

  // ************************************************************
  // AHB-Lite encodings
  // ************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    RCRP_GATE_RUN = 2'b00,
    RCRP_GATE_OCP = 2'b01,
    RCRP_GATE_OVP = 2'b10,
    RCRP_GATE_NVP = 2'b11
  } rcrp_gate_t;

endpackage : rcrp_pkg

// [rtl/rcrp_top.sv]
// Purpose: Current reporting, alert, quick response and fault latches of the graphics rail.
// Assumes: Analog comparators and the ADC sit outside and arrive as asynchronous levels/codes.
// Notes: The sensed-voltage code is signed millivolts; the ADC code is stable when sampled.

// Contract
// - Convert the 0 to 3.3 V current monitor voltage into an 8-bit code, 255 steps.
// - Code reaching 255 drives alert low and sets status bit 2.
// - Alert releases only once the current code falls to 242 or below.
// - Status bit 2 clears only at code 242 or below plus host status read.
// - Start quick-response pulse when mirrored feedback current exceeds the 5 uA trigger.
// - Active quick-response pulse replaces the normal on-time for the cycle.
// - High-side gate held off while current-limit comparator is tripped.
// - Overcurrent for 15 consecutive switching cycles sets the overcurrent latch.
// - Overcurrent counter resets when the condition is absent before 15 cycles.
// - Overcurrent latch tri-states PWM output and disables gate-drive logic; if overvoltage also latched, overvoltage gating wins, pwm_oe high.
// - Overcurrent latch requests a soft shutdown of the core rail.
// - Overvoltage is monitored from power-on reset on, via the negative sense input.
// - Overvoltage latch sets when sensed output exceeds max VID plus 150 mV.
// - Overvoltage margin becomes 850 mV if offset pin exceeded 0.9 V before power-up.
// - Overvoltage latch commands low-side on and high-side off.
// - Overvoltage latch requests a shutdown of the core rail.
// - Overvoltage comparator result accepted only after 1 us persistence.
// - Under overvoltage latch, output below -0.05 V turns low-side off, high-side off.
// - After negative guard acts, low-side turns on again once output rises above 0 V.
// - Negative guard enabled only with overvoltage latch set, filtered 1 us.
module rcrp_top
  import rcrp_pkg::*;
#(
  parameter int unsigned CODE_W = 8,
  parameter int unsigned MV_W = 13
) (
  input wire logic ref_clk,
  input wire logic srst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog-side inputs, asynchronous to ref_clk.
  input wire logic [CODE_W-1:0] current_monitor_output,
  input wire logic current_monitor_feedback,
  input wire logic quick_response_width_set,
  input wire logic overcurrent_threshold_set,
  input wire logic signed [MV_W-1:0] sense_negative_input,
  input wire logic [11:0] offset_setting_pin,
  input wire logic cycle_start,
  input wire logic normal_on_time,
  // Outputs.
  output logic alert_n,
  output logic high_side_gate,
  output logic low_side_gate,
  output logic pwm_out,
  output logic pwm_oe,
  output logic core_rail_shutdown_req,
  output logic overcurrent_latch,
  output logic overvoltage_latch,
  output logic negative_voltage_guard
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [CODE_W-1:0] cur_s1_q, cur_s2_q;
  logic signed [MV_W-1:0] vs_s1_q, vs_s2_q;
  logic [11:0] ofs_s1_q, ofs_s2_q;
  logic [4:0] bit_s1_q, bit_s2_q;
  logic mirror_trip, qr_width, ilim_trip, cyc_in, on_in;

  // Every external level passes two flops; stage one feeds stage two only.
  always_ff @(posedge ref_clk) begin
    cur_s1_q <= current_monitor_output;
    cur_s2_q <= cur_s1_q;
    vs_s1_q <= sense_negative_input;
    vs_s2_q <= vs_s1_q;
    ofs_s1_q <= offset_setting_pin;
    ofs_s2_q <= ofs_s1_q;
    bit_s1_q <= {current_monitor_feedback, quick_response_width_set,
                 overcurrent_threshold_set, cycle_start, normal_on_time};
    bit_s2_q <= bit_s1_q;
  end

  assign mirror_trip = bit_s2_q[4];
  assign qr_width = bit_s2_q[3];
  assign ilim_trip = bit_s2_q[2];
  assign cyc_in = bit_s2_q[1];
  assign on_in = bit_s2_q[0];

  // ************************************************************
  // Current code, alert and status
  // ************************************************************
  logic [7:0] out_current_q;
  logic icc_alert_q;
  logic icc_status_q;
  logic status_read;

  // The ADC code spans 0 to 3.3 V in 255 steps; it is registered here.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_current_q <= 8'h00;
    end else begin
      out_current_q <= cur_s2_q[7:0];
    end
  end

  // Alert sets at full scale and holds until the code falls to the release point.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      icc_alert_q <= 1'b0;
    end else if (out_current_q == CUR_CODE_MAX) begin
      icc_alert_q <= 1'b1;
    end else if (out_current_q <= CUR_CODE_RELEASE) begin
      icc_alert_q <= 1'b0;
    end
  end

  // Status bit is sticky; a full-scale code in the read cycle wins over the clear.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      icc_status_q <= 1'b0;
    end else if (out_current_q == CUR_CODE_MAX) begin
      icc_status_q <= 1'b1;
    end else if (status_read && out_current_q <= CUR_CODE_RELEASE) begin
      icc_status_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~((out_current_q == CUR_CODE_MAX) | icc_alert_q);
    end
  end

  // ************************************************************
  // Offset strap and overvoltage threshold
  // ************************************************************
  logic [1:0] strap_cnt_q;
  logic ofs_high_q;
  logic [11:0] max_vid_q;
  logic signed [MV_W:0] ov_limit;

  // The strap is caught two cycles after release, once the synchroniser holds a real value.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      strap_cnt_q <= 2'h0;
      ofs_high_q <= 1'b0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) begin
        ofs_high_q <= (ofs_s2_q > OFS_STRAP_MV);
      end
    end
  end

  // Threshold is max VID plus 150 mV, or plus 850 mV with the offset strap high.
  assign ov_limit = $signed({2'b00, max_vid_q}) +
                    $signed({2'b00, (ofs_high_q ? OV_MARGIN_OFS_MV : OV_MARGIN_MV)});

  // ************************************************************
  // Overvoltage and negative-voltage filters
  // ************************************************************
  logic [7:0] ov_cnt_q, nv_cnt_q;
  logic ov_raw, nv_raw, nv_clear_raw;
  logic nvp_q;

  assign ov_raw = ($signed({vs_s2_q[MV_W-1], vs_s2_q}) > ov_limit) && (strap_cnt_q == 2'h3);
  assign nv_raw = (vs_s2_q < NV_TRIP_MV);
  assign nv_clear_raw = (vs_s2_q > $signed({MV_W{1'b0}}));

  // Comparator must persist 1 us before the latch is taken; a glitch restarts the count.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ov_cnt_q <= 8'h00;
      overvoltage_latch <= 1'b0;
    end else if (!overvoltage_latch) begin
      if (!ov_raw) begin
        ov_cnt_q <= 8'h00;
      end else if (ov_cnt_q == 8'(OV_FILTER_CYC - 1)) begin
        overvoltage_latch <= 1'b1;
      end else begin
        ov_cnt_q <= ov_cnt_q + 8'h01;
      end
    end
  end

  // Negative guard only runs under the overvoltage latch; trip filtered, release above 0 V.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nv_cnt_q <= 8'h00;
      nvp_q <= 1'b0;
    end else if (!overvoltage_latch) begin
      nv_cnt_q <= 8'h00;
      nvp_q <= 1'b0;
    end else if (nvp_q) begin
      nv_cnt_q <= 8'h00;
      if (nv_clear_raw) begin
        nvp_q <= 1'b0;
      end
    end else if (!nv_raw) begin
      nv_cnt_q <= 8'h00;
    end else if (nv_cnt_q == 8'(NV_FILTER_CYC - 1)) begin
      nvp_q <= 1'b1;
    end else begin
      nv_cnt_q <= nv_cnt_q + 8'h01;
    end
  end

  // ************************************************************
  // Overcurrent cycle counter
  // ************************************************************
  logic [3:0] oc_cnt_q;
  logic cyc_d_q;
  logic cyc_edge;
  logic oc_in_cycle_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cyc_d_q <= 1'b0;
    end else begin
      cyc_d_q <= cyc_in;
    end
  end
  assign cyc_edge = cyc_in & ~cyc_d_q;

  // Each switching cycle remembers whether the limit tripped at any time in it.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oc_in_cycle_q <= 1'b0;
    end else if (cyc_edge) begin
      oc_in_cycle_q <= ilim_trip;
    end else if (ilim_trip) begin
      oc_in_cycle_q <= 1'b1;
    end
  end

  // A clean cycle restarts the count; fifteen tripped cycles in a row latch.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oc_cnt_q <= 4'h0;
      overcurrent_latch <= 1'b0;
    end else if (cyc_edge && !overcurrent_latch) begin
      if (!oc_in_cycle_q) begin
        oc_cnt_q <= 4'h0;
      end else if (oc_cnt_q == 4'(OC_LATCH_CYCLES - 1)) begin
        overcurrent_latch <= 1'b1;
      end else begin
        oc_cnt_q <= oc_cnt_q + 4'h1;
      end
    end
  end

  // ************************************************************
  // Quick response and gate drive
  // ************************************************************
  logic qr_active_q;
  logic mirror_d_q;
  rcrp_gate_t gate_mode;

  // A rising trip of the mirrored current starts a pulse whose width follows the width input.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mirror_d_q <= 1'b0;
      qr_active_q <= 1'b0;
    end else begin
      mirror_d_q <= mirror_trip;
      if (mirror_trip && !mirror_d_q) begin
        qr_active_q <= 1'b1;
      end else if (!qr_width) begin
        qr_active_q <= 1'b0;
      end
    end
  end

  // Overvoltage outranks overcurrent so the output is clamped even if both latch.
  always_comb begin
    if (overvoltage_latch && nvp_q) begin
      gate_mode = RCRP_GATE_NVP;
    end else if (overvoltage_latch) begin
      gate_mode = RCRP_GATE_OVP;
    end else if (overcurrent_latch) begin
      gate_mode = RCRP_GATE_OCP;
    end else begin
      gate_mode = RCRP_GATE_RUN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      high_side_gate <= 1'b0;
      low_side_gate <= 1'b0;
      pwm_out <= 1'b0;
      pwm_oe <= 1'b0;
      negative_voltage_guard <= 1'b0;
      core_rail_shutdown_req <= 1'b0;
    end else begin
      negative_voltage_guard <= nvp_q;
      core_rail_shutdown_req <= overcurrent_latch | overvoltage_latch;
      case (gate_mode)
        RCRP_GATE_RUN: begin
          // Quick-response pulse overrides the normal on-time; the limit vetoes both.
          high_side_gate <= (qr_active_q ? 1'b1 : on_in) & ~ilim_trip;
          low_side_gate <= ~((qr_active_q ? 1'b1 : on_in) & ~ilim_trip);
          pwm_out <= (qr_active_q ? 1'b1 : on_in) & ~ilim_trip;
          pwm_oe <= 1'b1;
        end
        RCRP_GATE_OCP: begin
          high_side_gate <= 1'b0;
          low_side_gate <= 1'b0;
          pwm_out <= 1'b0;
          pwm_oe <= 1'b0;
        end
        RCRP_GATE_OVP: begin
          high_side_gate <= 1'b0;
          low_side_gate <= 1'b1;
          pwm_out <= 1'b0;
          pwm_oe <= 1'b1;
        end
        RCRP_GATE_NVP: begin
          high_side_gate <= 1'b0;
          low_side_gate <= 1'b0;
          pwm_out <= 1'b0;
          pwm_oe <= 1'b1;
        end
        default: begin
          high_side_gate <= 1'b0;
          low_side_gate <= 1'b0;
          pwm_out <= 1'b0;
          pwm_oe <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  logic dp_valid_q, dp_write_q;
  logic [7:0] dp_addr_q;
  logic addr_take;

  // Zero wait states: every data phase completes in one cycle with OKAY.
  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign status_read = addr_take && !hwrite && (haddr == REG_STATUS1);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dp_valid_q <= addr_take;
      if (addr_take) begin
        dp_write_q <= hwrite;
        dp_addr_q <= haddr;
      end
    end
  end

  // Max VID is the only writable register; writes elsewhere are ignored.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      max_vid_q <= MAX_VID_RESET;
    end else if (dp_valid_q && dp_write_q && dp_addr_q == REG_MAX_VID) begin
      max_vid_q <= hwdata[11:0];
    end
  end

  // Read data is registered at address phase so it stands for the data phase.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      case (haddr)
        REG_STATUS1: hrdata <= {29'h0, icc_status_q, 2'h0};
        REG_OUT_CURRENT: hrdata <= {24'h0, out_current_q};
        REG_MAX_VID: hrdata <= {20'h0, max_vid_q};
        REG_FAULTS: hrdata <= {28'h0, ofs_high_q, nvp_q, overvoltage_latch, overcurrent_latch};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : rcrp_top
